// *** core/mcid_regs.sv ***
// Read-only memory-model and cache-hierarchy identification registers
module mcid_regs
	import mcid_pkg::*;
#(
	parameter logic [2:0] ICB_VALUE = MCID_ICB_DEFAULT
)
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        l3_present,
	input  wire logic        impl_trap_zero,
	input  wire logic        rd_valid,
	input  wire logic        rd_sel,
	input  mcid_level_t      rd_level,
	input  wire logic        hyp_enabled,
	input  wire logic        host_trap_general,
	input  wire logic        id_group2_trap,
	input  wire logic        id_group3_trap,
	input  wire logic        id_group4_trap,
	input  wire logic        fine_trap_enable,
	input  wire logic        fine_read_trap,
	output logic             rsp_valid,
	output logic [63:0]      rsp_data,
	output logic             rsp_trap,
	output logic             rsp_trap_to_hyp,
	output logic [5:0]       rsp_class,
	output logic [63:0]      memory_model_feature_id_2,
	output logic [63:0]      cache_hierarchy_id
);
	import mcid_pkg::*;

	logic [63:0] feat_nxt;
	logic [63:0] cache_nxt;
	logic        trap;
	logic        to_hyp;

	always_comb begin
		feat_nxt = MCID_RESET_VAL;
		feat_nxt[MCID_F_END_OF_SPACE_FAULT_SUPPORT_LSB +: 4] = MCID_V_END_OF_SPACE_FAULT_SUPPORT;
		feat_nxt[MCID_F_EVT_LSB +: 4] = MCID_V_EVT;
		feat_nxt[MCID_F_BBM_LSB +: 4] = MCID_V_BBM;
		feat_nxt[MCID_F_TTL_LSB +: 4] = MCID_V_TTL;
		feat_nxt[MCID_F_FWB_LSB +: 4] = MCID_V_ONE;
		feat_nxt[MCID_F_IDS_LSB +: 4] = MCID_V_ONE;
		feat_nxt[MCID_F_AT_LSB +: 4] = MCID_V_ONE;
		feat_nxt[MCID_F_ST_LSB +: 4] = MCID_V_ONE;
		feat_nxt[MCID_F_CACHE_SIZE_FORMAT_EXT_LSB +: 4] = MCID_V_ONE;
		feat_nxt[MCID_F_IMPLICIT_ERROR_SYNC_SUPPORT_LSB +: 4] = MCID_V_ONE;
		feat_nxt[MCID_F_UAO_LSB +: 4] = MCID_V_ONE;
		feat_nxt[MCID_F_CNP_LSB +: 4] = MCID_V_ONE;
	end

	always_comb begin
		cache_nxt = MCID_RESET_VAL;
		cache_nxt[MCID_C_TK2_LSB +: 2] = MCID_TK_UNIFIED;
		cache_nxt[MCID_C_TK1_LSB +: 2] = MCID_TK_UNIFIED;
		cache_nxt[MCID_C_TK3_LSB +: 2] =
			l3_present ? MCID_TK_UNIFIED : MCID_TK_NONE;
		cache_nxt[MCID_C_ICB_LSB +: 3] = ICB_VALUE;
		cache_nxt[MCID_C_UNIFY_LEVEL_UNIPROC_LSB +: 3] = MCID_UNIFY_LEVEL_UNIPROC_VAL;
		cache_nxt[MCID_C_UNIFY_LEVEL_INNER_SHARED_LSB +: 3] = MCID_UNIFY_LEVEL_INNER_SHARED_VAL;
		cache_nxt[MCID_C_LOC_LSB +: 3] = l3_present ? MCID_LOC_L3 : MCID_LOC_L2;
		cache_nxt[MCID_C_CK3_LSB +: 3] =
			l3_present ? MCID_CK_UNIFIED : MCID_CK_NONE;
		cache_nxt[MCID_C_CK2_LSB +: 3] = MCID_CK_UNIFIED;
		cache_nxt[MCID_C_CK1_LSB +: 3] = MCID_CK_SPLIT;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			memory_model_feature_id_2 <= feat_nxt;
			cache_hierarchy_id <= cache_nxt;
		end
	end

	mcid_trap_decide u_trap (
		.is_cache          (rd_sel == MCID_SEL_CACHE),
		.level             (rd_level),
		.hyp_enabled       (hyp_enabled),
		.host_trap_general (host_trap_general),
		.id_group2_trap    (id_group2_trap),
		.id_group3_trap    (id_group3_trap),
		.id_group4_trap    (id_group4_trap),
		.fine_trap_enable  (fine_trap_enable),
		.fine_read_trap    (fine_read_trap),
		.feature_nonzero   (|memory_model_feature_id_2),
		.impl_trap_zero    (impl_trap_zero),
		.trap              (trap),
		.trap_to_hyp       (to_hyp)
	);

	// One-cycle read answer; trapped reads return zero data
	always_ff @(posedge clk) begin
		if (reset) begin
			rsp_valid <= 1'b0;
			rsp_data <= MCID_RESET_VAL;
			rsp_trap <= 1'b0;
			rsp_trap_to_hyp <= 1'b0;
			rsp_class <= 6'h0;
		end else begin
			rsp_valid <= rd_valid;
			rsp_trap <= rd_valid & trap;
			rsp_trap_to_hyp <= rd_valid & trap & to_hyp;
			rsp_class <= (rd_valid & trap) ? MCID_TRAP_CLASS : 6'h0;
			if (rd_valid & ~trap)
				rsp_data <= (rd_sel == MCID_SEL_CACHE) ?
					cache_hierarchy_id : memory_model_feature_id_2;
			else
				rsp_data <= MCID_RESET_VAL;
		end
	end
endmodule

// *** shared/mcid_pkg.sv ***
// Constants for the memory-model and cache-hierarchy identification block
package mcid_pkg;
	typedef enum logic [1:0] {
		MCID_PL_USER,
		MCID_PL_KERNEL,
		MCID_PL_HYP,
		MCID_PL_MON
	} mcid_level_t;

	localparam logic [5:0] MCID_TRAP_CLASS   = 6'h18;
	// Register select codes on the read request port
	localparam logic       MCID_SEL_FEATURE  = 1'h0;
	localparam logic       MCID_SEL_CACHE    = 1'h1;

	// Feature register field positions (low bit) and values
	localparam int         MCID_F_END_OF_SPACE_FAULT_SUPPORT_LSB   = 60;
	localparam int         MCID_F_EVT_LSB    = 56;
	localparam int         MCID_F_BBM_LSB    = 52;
	localparam int         MCID_F_TTL_LSB    = 48;
	localparam int         MCID_F_FWB_LSB    = 40;
	localparam int         MCID_F_IDS_LSB    = 36;
	localparam int         MCID_F_AT_LSB     = 32;
	localparam int         MCID_F_ST_LSB     = 28;
	localparam int         MCID_F_CACHE_SIZE_FORMAT_EXT_LSB  = 20;
	localparam int         MCID_F_IMPLICIT_ERROR_SYNC_SUPPORT_LSB   = 12;
	localparam int         MCID_F_UAO_LSB    = 4;
	localparam int         MCID_F_CNP_LSB    = 0;
	localparam logic [3:0] MCID_V_END_OF_SPACE_FAULT_SUPPORT       = 4'h1;
	localparam logic [3:0] MCID_V_EVT        = 4'h2;
	localparam logic [3:0] MCID_V_BBM        = 4'h2;
	localparam logic [3:0] MCID_V_TTL        = 4'h1;
	localparam logic [3:0] MCID_V_ONE        = 4'h1;

	// Cache hierarchy register field positions and values
	localparam int         MCID_C_TK3_LSB    = 37;
	localparam int         MCID_C_TK2_LSB    = 35;
	localparam int         MCID_C_TK1_LSB    = 33;
	localparam int         MCID_C_ICB_LSB    = 30;
	localparam int         MCID_C_UNIFY_LEVEL_UNIPROC_LSB   = 27;
	localparam int         MCID_C_LOC_LSB    = 24;
	localparam int         MCID_C_UNIFY_LEVEL_INNER_SHARED_LSB  = 21;
	localparam int         MCID_C_CK3_LSB    = 6;
	localparam int         MCID_C_CK2_LSB    = 3;
	localparam int         MCID_C_CK1_LSB    = 0;
	localparam logic [1:0] MCID_TK_NONE      = 2'h0;
	localparam logic [1:0] MCID_TK_UNIFIED   = 2'h2;
	localparam logic [2:0] MCID_UNIFY_LEVEL_UNIPROC_VAL     = 3'h0;
	localparam logic [2:0] MCID_UNIFY_LEVEL_INNER_SHARED_VAL    = 3'h0;
	localparam logic [2:0] MCID_LOC_L2       = 3'h2;
	localparam logic [2:0] MCID_LOC_L3       = 3'h3;
	localparam logic [2:0] MCID_CK_NONE      = 3'h0;
	localparam logic [2:0] MCID_CK_SPLIT     = 3'h3;
	localparam logic [2:0] MCID_CK_UNIFIED   = 3'h4;
	localparam logic [2:0] MCID_ICB_DEFAULT  = 3'h0;
	localparam logic [63:0] MCID_RESET_VAL   = 64'h0;
endpackage

// *** core/mcid_trap_decide.sv ***
// Trap decision for one identification register read
module mcid_trap_decide
	import mcid_pkg::*;
(
	input  wire logic        is_cache,
	input  mcid_level_t      level,
	input  wire logic        hyp_enabled,
	input  wire logic        host_trap_general,
	input  wire logic        id_group2_trap,
	input  wire logic        id_group3_trap,
	input  wire logic        id_group4_trap,
	input  wire logic        fine_trap_enable,
	input  wire logic        fine_read_trap,
	input  wire logic        feature_nonzero,
	input  wire logic        impl_trap_zero,
	output logic             trap,
	output logic             trap_to_hyp
);
	always_comb begin
		trap = 1'b0;
		trap_to_hyp = 1'b0;
		case (level)
			MCID_PL_USER: begin
				trap = 1'b1;
				trap_to_hyp = hyp_enabled & host_trap_general;
			end
			MCID_PL_KERNEL: begin
				if (is_cache) begin
					trap = hyp_enabled & (id_group2_trap | id_group4_trap
						| (fine_trap_enable & fine_read_trap));
				end else begin
					trap = hyp_enabled & id_group3_trap
						& (feature_nonzero | impl_trap_zero);
				end
				trap_to_hyp = trap;
			end
			default: begin
				trap = 1'b0;
				trap_to_hyp = 1'b0;
			end
		endcase
	end
endmodule

// *** dv/mcid_regs_properties.sv ***
// Concurrent checks on the identification register block ports
module mcid_regs_properties
	import mcid_pkg::*;
(
	input  wire logic   clk,
	input  wire logic   reset,
	input  wire logic   l3_present,
	input  wire logic   rd_valid,
	input  wire logic   rd_sel,
	input  mcid_level_t rd_level,
	input  wire logic   hyp_enabled,
	input  wire logic   host_trap_general,
	input  wire logic   id_group2_trap,
	input  wire logic   id_group3_trap,
	input  wire logic   id_group4_trap,
	input  wire logic   fine_trap_enable,
	input  wire logic   fine_read_trap,
	input  wire logic   rsp_valid,
	input  wire logic   [63:0] rsp_data,
	input  wire logic   rsp_trap,
	input  wire logic   rsp_trap_to_hyp,
	input  wire logic   [5:0] rsp_class,
	input  wire logic   [63:0] memory_model_feature_id_2,
	input  wire logic   [63:0] cache_hierarchy_id
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	idle_quiet_a: assert property (!rd_valid |=> !rsp_valid && !rsp_trap)
		else $error("response without request");
	user_trap_a: assert property (rd_valid && rd_level == MCID_PL_USER
		|=> rsp_trap && rsp_class == 6'h18 && rsp_data == 64'h0
		&& rsp_trap_to_hyp == $past(hyp_enabled && host_trap_general))
		else $error("user read trap wrong");
	high_read_a: assert property (rd_valid && rd_level[1] |=> rsp_valid
		&& !rsp_trap && rsp_data == ($past(rd_sel) ? cache_hierarchy_id
		: memory_model_feature_id_2)) else $error("high level read wrong");
	feat_kernel_a: assert property (rd_valid && !rd_sel
		&& rd_level == MCID_PL_KERNEL
		|=> rsp_trap == $past(hyp_enabled && id_group3_trap))
		else $error("kernel feature trap wrong");
	cache_kernel_a: assert property (rd_valid && rd_sel
		&& rd_level == MCID_PL_KERNEL |=> rsp_trap == $past(hyp_enabled
		&& (id_group2_trap || id_group4_trap
		|| fine_trap_enable && fine_read_trap)))
		else $error("kernel cache trap wrong");
	kernel_dest_a: assert property (rsp_trap
		&& $past(rd_level) == MCID_PL_KERNEL
		|-> rsp_trap_to_hyp && rsp_class == 6'h18)
		else $error("kernel trap target wrong");
	feat_value_a: assert property (
		memory_model_feature_id_2 == 64'h1221_0111_1010_1011)
		else $error("feature value wrong");
	l3_fields_a: assert property ({cache_hierarchy_id[38:37],
		cache_hierarchy_id[26:24], cache_hierarchy_id[8:6]}
		== (l3_present ? 8'h9c : 8'h10)) else $error("l3 fields wrong");
	id_const_a: assert property ($stable(cache_hierarchy_id)
		&& $stable(memory_model_feature_id_2)) else $error("id changed");
endmodule

bind mcid_regs mcid_regs_properties i_chk (.*);

// *** dv/tb_mcid_regs.sv ***
// Self-checking bench for the identification register block
module tb_mcid_regs;
	timeunit 1ns;
	timeprecision 1ns;
	import mcid_pkg::*;
	localparam logic [63:0] FEAT = 64'h1221_0111_1010_1011;
	localparam logic [63:0] C3   = 64'h0000_0054_0300_0123;
	localparam logic [63:0] C2   = 64'h0000_0014_0200_0023;
	logic clk = 1'b0, reset = 1'b1, l3_present = 1'b1;
	logic impl_trap_zero = 1'b0, rd_valid = 1'b0, rd_sel = 1'b0;
	mcid_level_t rd_level = MCID_PL_USER;
	logic hyp_enabled = 0, host_trap_general = 0, id_group2_trap = 0;
	logic id_group3_trap = 0, id_group4_trap = 0, fine_trap_enable = 0;
	logic fine_read_trap = 0, rsp_valid, rsp_trap, rsp_trap_to_hyp;
	logic [63:0] rsp_data, memory_model_feature_id_2, cache_hierarchy_id;
	logic [5:0] rsp_class;
	int n_mismatch = 0, comparisons = 0;

	mcid_regs i_dut (.*);

	always #25 clk = ~clk;

	task automatic chk(string n, logic [63:0] e, logic [63:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Random reads, back to back; model answers one cycle late
	task automatic run(logic l3);
		logic [31:0] r;
		logic ev, et, eh;
		logic [63:0] ed;
		ev = 0; et = 0; eh = 0; ed = 0;
		@(posedge clk);
		l3_present <= l3;
		// Stale request must not fire on the first edge after release
		rd_valid <= 1'b0;
		reset <= 1'b1;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 200; i++) begin
			@(posedge clk);
			r = $urandom;
			rd_valid <= r[0];
			rd_sel <= r[1];
			rd_level <= mcid_level_t'(r[3:2]);
			{hyp_enabled, host_trap_general, id_group2_trap, id_group3_trap,
				id_group4_trap, fine_trap_enable, fine_read_trap} <= r[10:4];
			impl_trap_zero <= r[11];
			@(negedge clk);
			chk("rsp_valid", ev, rsp_valid);
			chk("rsp_trap", et, rsp_trap);
			chk("rsp_data", ed, rsp_data);
			chk("rsp_class", et ? 6'h18 : 6'h0, rsp_class);
			chk("rsp_trap_to_hyp", et & eh, rsp_trap_to_hyp);
			ev = r[0];
			et = r[0] && (r[3:2] == 0 || r[3:2] == 1 && r[10]
				&& (r[1] ? r[8] | r[6] | r[5] & r[4] : r[7]));
			eh = r[3:2] != 0 || r[10] & r[9];
			ed = (et || !r[0]) ? 64'h0 : r[1] ? (l3 ? C3 : C2) : FEAT;
		end
		chk("feature_id", FEAT, memory_model_feature_id_2);
		chk("cache_id", l3 ? C3 : C2, cache_hierarchy_id);
		$display("test l3_present=%0d done", l3);
	endtask

	initial begin
		void'($urandom(32'hc6a4330a));
		run(1'b1);
		run(1'b0);
		summarize();
	end

	// Whole run is near 422 cycles
	initial begin
		repeat (3000) @(posedge clk);
		n_mismatch++;
		summarize();
	end
endmodule
